// ---- inc/gdr_pkg.sv ----
package gdr_pkg;
    // Clock and line limits
    localparam int CLK_MHZ = 250;
    localparam int LINE_LIMIT_MHZ = 250;
    localparam int SYNC_HOLD_NS = 20;
    localparam int SYNC_HOLD_CYC = (SYNC_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int DLY_STEPS = 128;
    localparam int DLY_STEP_FS = 12500;
    localparam logic [6:0] DLY_MAX = 7'(DLY_STEPS - 1);
    localparam logic [6:0] DLY_RST = 7'h00;
    localparam logic [3:0] DLL_LOCK_CODE = 4'h9;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DCMD = 8'h04;
    localparam logic [7:0] OFS_MARGIN = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_WORD = 8'h10;
    // Gearing codes
    localparam logic [1:0] GEAR_X1 = 2'h0;
    localparam logic [1:0] GEAR_X2 = 2'h1;
    localparam logic [1:0] GEAR_X4 = 2'h2;
    // Default data delays per variant
    localparam logic [6:0] DEF_X1_CEN = 7'h10;
    localparam logic [6:0] DEF_X1_ALN = 7'h18;
    localparam logic [6:0] DEF_X2_CEN = 7'h20;
    localparam logic [6:0] DEF_X2_ALN = 7'h28;
    localparam logic [6:0] DEF_X4_CEN = 7'h30;
    localparam logic [6:0] DEF_X4_ALN = 7'h38;

    typedef enum logic [2:0] {ST_IDLE, ST_LOCK, ST_UPDATE, ST_STOP, ST_GREL, ST_RUN} gdr_state_t;

    typedef struct packed {
        logic dyn;
        logic fast;
        logic [1:0] gear;
        logic aln;
        logic en;
    } gdr_ctrl_t;

    typedef struct packed {
        logic load;
        logic dir;
        logic step;
    } gdr_cmd_t;

    typedef struct packed {
        logic [11:0] rsvd_hi;
        logic [3:0] dl_code;
        logic rsvd_lo;
        logic [6:0] dly;
        logic cfg_err;
        logic grst;
        logic stop;
        logic freeze;
        logic lock;
        logic [2:0] state;
    } gdr_stat_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } gdr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } gdr_apb_rsp_t;
endpackage : gdr_pkg

// ---- rtl/gdr_rx_gearing.sv ----
`timescale 1ns/1ns
module gdr_rx_gearing #(
    parameter int HIST_D = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire gdr_pkg::gdr_apb_req_t apb_req,
    output gdr_pkg::gdr_apb_rsp_t apb_rsp,
    input wire logic line_clk_pin,
    input wire logic line_data_pin,
    output logic [7:0] rx_word,
    output logic rx_valid,
    output logic slow_clk
);
    import gdr_pkg::*;

    if (HIST_D < 16) begin : g_chk
        $error("HIST_D must be at least 16");
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    gdr_apb_rsp_t rsp_ff;
    gdr_ctrl_t ctrl_ff;
    gdr_state_t state_ff;
    gdr_stat_t stat;
    logic [1:0] clk_sync_ff, dat_sync_ff;
    logic [HIST_D-1:0] chist_ff, dhist_ff;
    logic [3:0] margin_ff, dll_code_ff, dl_code_ff, ph_idx, nbits;
    logic [6:0] dly_ff, dly_def;
    logic [7:0] word_ff, nxt_word, mask;
    logic [2:0] bcnt_ff, half;
    logic [7:0] tmr_ff;
    logic lock_ff, freeze_ff, stop_ff, grst_ff, started_ff, valid_ff, slow_ff;
    logic dclk, dclk_prev_ff, rise, fall, edge_ev, dbit, cfg_err;
    logic acc, wr_go, addr_ok, cmd_wr;
    gdr_cmd_t cmd;
    logic [31:0] rdata;

    // Pin synchronisers; only the second stage feeds the history lines
    always_ff @(posedge clk) begin
        if (reset) begin
            clk_sync_ff <= 2'h0;
            dat_sync_ff <= 2'h0;
        end else begin
            clk_sync_ff <= {clk_sync_ff[0], line_clk_pin};
            dat_sync_ff <= {dat_sync_ff[0], line_data_pin};
        end
    end

    // Tapped history lines stand in for the delay cells
    always_ff @(posedge clk) begin
        if (reset) begin
            chist_ff <= '0;
            dhist_ff <= '0;
        end else begin
            chist_ff <= {chist_ff[HIST_D-2:0], clk_sync_ff[1]};
            dhist_ff <= {dhist_ff[HIST_D-2:0], dat_sync_ff[1]};
        end
    end

    // APB decode; writes land at the edge that samples pready high
    assign acc = apb_req.psel && apb_req.penable && !rsp_ff.pready;
    assign wr_go = apb_req.psel && apb_req.penable && rsp_ff.pready && apb_req.pwrite;
    assign addr_ok = (apb_req.paddr == OFS_CTRL) || (apb_req.paddr == OFS_DCMD) ||
        (apb_req.paddr == OFS_MARGIN) || (apb_req.paddr == OFS_STAT) ||
        (apb_req.paddr == OFS_WORD);
    assign cmd_wr = wr_go && (apb_req.paddr == OFS_DCMD);
    assign cmd = gdr_cmd_t'(apb_req.pwdata[2:0]);

    // Status view of the block's own state
    always_comb begin
        stat = '0;
        stat.state = 3'(state_ff);
        stat.lock = lock_ff;
        stat.freeze = freeze_ff;
        stat.stop = stop_ff;
        stat.grst = grst_ff;
        stat.cfg_err = cfg_err;
        stat.dly = dly_ff;
        stat.dl_code = dl_code_ff;
    end

    // Read mux; command register reads as zero
    always_comb begin
        case (apb_req.paddr)
            OFS_CTRL: rdata = 32'(ctrl_ff);
            OFS_MARGIN: rdata = 32'(margin_ff);
            OFS_STAT: rdata = 32'(stat);
            OFS_WORD: rdata = 32'(rx_word); // Masked word, not the raw shifter
            default: rdata = 32'h0000_0000;
        endcase
    end

    // One wait state: pready rises on the second access cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.pready <= acc;
            rsp_ff.pslverr <= acc && !addr_ok;
            rsp_ff.prdata <= (acc && !apb_req.pwrite) ? rdata : 32'h0000_0000;
        end
    end

    // Control and margin registers
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_ff <= '0;
            margin_ff <= 4'h0;
        end else if (wr_go && apb_req.paddr == OFS_CTRL) begin
            ctrl_ff <= gdr_ctrl_t'(apb_req.pwdata[5:0]);
        end else if (wr_go && apb_req.paddr == OFS_MARGIN) begin
            margin_ff <= apb_req.pwdata[3:0];
        end
    end

    // Line rate must match the clock tree of the chosen gearing
    assign cfg_err = (ctrl_ff.gear == GEAR_X1 && ctrl_ff.fast) ||
        (ctrl_ff.gear != GEAR_X1 && !ctrl_ff.fast) ||
        (ctrl_ff.gear == 2'h3);

    // Bits per slow cycle and divider half point
    always_comb begin
        case (ctrl_ff.gear)
            GEAR_X2: nbits = 4'h4;
            GEAR_X4: nbits = 4'h8;
            default: nbits = 4'h2;
        endcase
        half = 3'(nbits >> 1);
    end

    // Default delay chosen by variant
    always_comb begin
        case ({ctrl_ff.gear, ctrl_ff.aln})
            {GEAR_X1, 1'b1}: dly_def = DEF_X1_ALN;
            {GEAR_X2, 1'b0}: dly_def = DEF_X2_CEN;
            {GEAR_X2, 1'b1}: dly_def = DEF_X2_ALN;
            {GEAR_X4, 1'b0}: dly_def = DEF_X4_CEN;
            {GEAR_X4, 1'b1}: dly_def = DEF_X4_ALN;
            default: dly_def = DEF_X1_CEN;
        endcase
    end

    // Data delay setting; static mode pins it to the default
    always_ff @(posedge clk) begin
        if (reset) begin
            dly_ff <= DLY_RST;
        end else if (!ctrl_ff.dyn || (cmd_wr && cmd.load)) begin
            dly_ff <= dly_def;
        end else if (cmd_wr && cmd.step) begin
            if (cmd.dir && dly_ff != DLY_MAX) begin
                dly_ff <= dly_ff + 7'h01;
            end else if (!cmd.dir && dly_ff != 7'h00) begin
                dly_ff <= dly_ff - 7'h01;
            end
        end
    end

    // Eight steps per tap: coarse model of the fine delay cell
    assign dbit = dhist_ff[dly_ff[6:3]];

    // Phase tap wraps; margin is meant for small test offsets
    assign ph_idx = dl_code_ff + margin_ff;
    assign dclk = ctrl_ff.aln ? chist_ff[ph_idx] : chist_ff[0];
    assign rise = dclk && !dclk_prev_ff;
    assign fall = !dclk && dclk_prev_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            dclk_prev_ff <= 1'b0;
        end else begin
            dclk_prev_ff <= dclk;
        end
    end

    // Lock loop runs on the delayed clock it steers
    always_ff @(posedge clk) begin
        if (reset || state_ff == ST_IDLE) begin
            dll_code_ff <= 4'h0;
            lock_ff <= 1'b0;
        end else if (ctrl_ff.aln && rise && !lock_ff) begin
            dll_code_ff <= dll_code_ff + 4'h1;
            lock_ff <= (dll_code_ff + 4'h1) == DLL_LOCK_CODE;
        end
    end

    // Delay line takes codes only at update or once unfrozen
    always_ff @(posedge clk) begin
        if (reset || state_ff == ST_IDLE) begin
            dl_code_ff <= 4'h0;
        end else if (state_ff == ST_UPDATE || (!freeze_ff && ctrl_ff.aln)) begin
            dl_code_ff <= dll_code_ff;
        end
    end

    // Startup sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            tmr_ff <= 8'h00;
        end else if (!ctrl_ff.en || cfg_err) begin
            state_ff <= ST_IDLE;
            tmr_ff <= 8'h00;
        end else begin
            case (state_ff)
                ST_IDLE: state_ff <= ctrl_ff.aln ? ST_LOCK : ST_STOP;
                ST_LOCK: if (lock_ff) begin
                    state_ff <= ST_UPDATE;
                end
                ST_UPDATE: state_ff <= ST_STOP;
                ST_STOP, ST_GREL: begin
                    if (tmr_ff == 8'(SYNC_HOLD_CYC - 1)) begin
                        tmr_ff <= 8'h00;
                        state_ff <= (state_ff == ST_STOP) ? ST_GREL : ST_RUN;
                    end else begin
                        tmr_ff <= tmr_ff + 8'h01;
                    end
                end
                ST_RUN: state_ff <= ST_RUN;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Freeze, stop and gearing reset derived from the sequence
    always_ff @(posedge clk) begin
        if (reset) begin
            freeze_ff <= 1'b1;
            stop_ff <= 1'b1;
            grst_ff <= 1'b1;
        end else begin
            if (state_ff == ST_IDLE) begin
                freeze_ff <= 1'b1;
            end else if (state_ff == ST_UPDATE) begin
                freeze_ff <= 1'b0;
            end
            stop_ff <= !(state_ff == ST_GREL && tmr_ff == 8'(SYNC_HOLD_CYC - 1)) &&
                state_ff != ST_RUN;
            grst_ff <= !(state_ff == ST_STOP && tmr_ff == 8'(SYNC_HOLD_CYC - 1)) &&
                state_ff != ST_GREL && state_ff != ST_RUN;
        end
    end

    // Capture: first accepted edge is a rising one so words stay in phase
    assign edge_ev = !stop_ff && (rise || fall) && (started_ff || rise);
    assign nxt_word = {word_ff[6:0], dbit};
    assign mask = 8'((9'h001 << nbits) - 9'h001);

    always_ff @(posedge clk) begin
        if (reset || grst_ff) begin
            word_ff <= 8'h00;
            bcnt_ff <= 3'h0;
            started_ff <= 1'b0;
            valid_ff <= 1'b0;
            slow_ff <= 1'b0;
            rx_word <= 8'h00;
        end else begin
            valid_ff <= 1'b0;
            if (edge_ev) begin
                started_ff <= 1'b1;
                word_ff <= nxt_word;
                if (bcnt_ff == 3'(nbits - 4'h1)) begin
                    bcnt_ff <= 3'h0;
                    rx_word <= nxt_word & mask;
                    valid_ff <= 1'b1;
                end else begin
                    bcnt_ff <= bcnt_ff + 3'h1;
                end
                if (bcnt_ff == 3'h0) begin
                    slow_ff <= 1'b1;
                end else if (bcnt_ff == half) begin
                    slow_ff <= 1'b0;
                end
            end
        end
    end

    assign rx_valid = valid_ff;
    assign slow_clk = slow_ff;
    assign apb_rsp = rsp_ff;

    sequence s_upd;
        state_ff == ST_UPDATE ##1 (!freeze_ff && dl_code_ff == DLL_LOCK_CODE);
    endsequence

    sequence s_acc;
        apb_req.psel && apb_req.penable && !rsp_ff.pready;
    endsequence

    apb_ready_a: assert property (s_acc |=> rsp_ff.pready ##1 !rsp_ff.pready)
        else $error("pready not a single wait-state pulse");
    apb_err_a: assert property ((s_acc and !addr_ok) |=> rsp_ff.pslverr)
        else $error("unmapped access without pslverr");
    rate_check_a: assert property (cfg_err |=> state_ff == ST_IDLE)
        else $error("capture running with mismatched gearing");
    dly_load_a: assert property (cmd_wr && cmd.load && ctrl_ff.dyn |=> dly_ff == $past(dly_def))
        else $error("load did not restore default delay");
    dly_step_a: assert property (cmd_wr && !cmd.load && cmd.step && cmd.dir && ctrl_ff.dyn &&
        dly_ff != DLY_MAX |=> dly_ff == $past(dly_ff) + 7'h01)
        else $error("delay step not applied");
    no_early_a: assert property ($changed(dl_code_ff) && state_ff != ST_IDLE |-> $past(lock_ff))
        else $error("delay line updated before lock");
    unfreeze_a: assert property (state_ff == ST_LOCK && lock_ff && ctrl_ff.en && !cfg_err |=> s_upd)
        else $error("freeze released out of order");
    stop_hold_a: assert property ($fell(grst_ff) |-> stop_ff [*5] ##1 !stop_ff)
        else $error("stop not held across gearing reset release");
    word_bits_a: assert property (valid_ff |-> $past(bcnt_ff) == 3'(nbits - 4'h1))
        else $error("word emitted with wrong bit count");
endmodule : gdr_rx_gearing

// ---- verif/gdr_tx_model.sv ----
`timescale 1ns/1ns
// Forwarding transmitter; its clock stands low between frames
module gdr_tx_model (
    input wire logic clk,
    output logic line_clk,
    output logic line_data
);
    // Quiet line at time zero
    initial begin
        line_clk = 1'b0;
        line_data = 1'b0;
    end

    // Oldest bit first, first edge rising, data moved midway between edges
    task automatic send(input logic [31:0] bits, input int nbits, input int half);
        for (int i = 0; i < nbits; i++) begin
            line_data <= bits[nbits-1-i];
            repeat (half / 2) @(posedge clk);
            line_clk <= ~line_clk;
            repeat (half - half / 2) @(posedge clk);
        end
        // Released data line shows the inverse, never a stale bit
        line_data <= ~line_data;
    endtask : send
endmodule : gdr_tx_model

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb;
    import gdr_pkg::*;
    logic clk;
    logic reset;
    gdr_apb_req_t req;
    gdr_apb_rsp_t rsp;
    logic line_clk;
    logic line_data;
    logic [7:0] rx_word;
    logic rx_valid;
    logic slow_clk;
    logic slow_q;
    logic [7:0] rxq[$];
    int slow_rises;
    int fails;
    int check_count;
    int cyc;
    int nb;
    logic [31:0] rd;
    logic err;
    logic [7:0] w1;
    logic [7:0] w2;
    logic [6:0] defs[6] = '{DEF_X1_CEN, DEF_X1_ALN, DEF_X2_CEN, DEF_X2_ALN, DEF_X4_CEN, DEF_X4_ALN};

    gdr_rx_gearing dut (
        .clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
        .line_clk_pin(line_clk), .line_data_pin(line_data),
        .rx_word(rx_word), .rx_valid(rx_valid), .slow_clk(slow_clk)
    );
    gdr_tx_model tx (.clk(clk), .line_clk(line_clk), .line_data(line_data));

    // 4 ns clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Collect words, count divided clock rises, cut a hang short
    always @(posedge clk) begin
        slow_q <= slow_clk;
        if (slow_clk === 1'b1 && slow_q === 1'b0) slow_rises++;
        if (rx_valid === 1'b1) rxq.push_back(rx_word);
        cyc++;
        if (cyc == 40000) begin
            fails++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        chk(32'(rsp.pready), 32'h1, "pready");
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask : xfer

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        req = '0;
        reset = 1'b1;
        fails = 0;
        check_count = 0;
        cyc = 0;
        slow_rises = 0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        xfer(1'b0, OFS_CTRL, 0);
        chk(rd, 0, "ctrl reset");
        xfer(1'b1, OFS_STAT, 32'hFFFF_FFFF);
        xfer(1'b0, OFS_STAT, 0);
        chk(32'(rd[2:0]), 32'(ST_IDLE), "idle state");
        xfer(1'b0, 8'h14, 0);
        chk(32'(err), 32'h1, "unmapped error");
        $display("test registers done");
        // Line rate must match gearing
        xfer(1'b1, OFS_CTRL, 32'h11);
        xfer(1'b0, OFS_STAT, 0);
        chk(32'(rd[7]), 32'h1, "x1 fast");
        xfer(1'b1, OFS_CTRL, 32'h05);
        xfer(1'b0, OFS_STAT, 0);
        chk(32'(rd[7]), 32'h1, "x2 slow");
        xfer(1'b1, OFS_CTRL, 32'h1D);
        xfer(1'b0, OFS_STAT, 0);
        chk(32'(rd[7]), 32'h1, "gear code 3");
        $display("test line rate done");
        // Dynamic delay: load, step, both clamps
        xfer(1'b1, OFS_CTRL, 32'h21);
        xfer(1'b1, OFS_DCMD, 32'h4);
        xfer(1'b0, OFS_STAT, 0);
        chk(32'(rd[14:8]), 32'(DEF_X1_CEN), "load");
        xfer(1'b1, OFS_DCMD, 32'h3);
        xfer(1'b0, OFS_STAT, 0);
        chk(32'(rd[14:8]), 32'(DEF_X1_CEN) + 1, "step up");
        repeat (20) xfer(1'b1, OFS_DCMD, 32'h1);
        xfer(1'b0, OFS_STAT, 0);
        chk(32'(rd[14:8]), 0, "floor");
        repeat (130) xfer(1'b1, OFS_DCMD, 32'h3);
        xfer(1'b0, OFS_STAT, 0);
        chk(32'(rd[14:8]), 32'(DLY_MAX), "ceiling");
        xfer(1'b1, OFS_DCMD, 32'h4);
        xfer(1'b0, OFS_DCMD, 0);
        chk(rd, 0, "command reads zero");
        xfer(1'b0, OFS_STAT, 0);
        chk(32'(rd[14:8]), 32'(DEF_X1_CEN), "reload");
        // Static mode keeps the default whatever is commanded
        xfer(1'b1, OFS_CTRL, 32'h01);
        xfer(1'b1, OFS_DCMD, 32'h3);
        xfer(1'b0, OFS_STAT, 0);
        chk(32'(rd[14:8]), 32'(DEF_X1_CEN), "static delay");
        xfer(1'b1, OFS_MARGIN, 32'h1F);
        xfer(1'b0, OFS_MARGIN, 0);
        chk(rd, 32'hF, "margin");
        $display("test delay done");
        // Every gearing, centered and aligned, two words back to back
        for (int g = 0; g < 3; g++) begin
            for (int a = 0; a < 2; a++) begin
                nb = 2 << g;
                xfer(1'b1, OFS_CTRL, 0);
                xfer(1'b1, OFS_CTRL, 32'(1 + 2 * a + 4 * g + ((g > 0) ? 16 : 0)));
                // Short half period so the last fall lands before the run state
                if (a == 1) tx.send(32'h0002_AAAA, 18, 5);
                repeat (30) @(posedge clk);
                xfer(1'b0, OFS_STAT, 0);
                // Centered variants never pass the update step, so freeze stays set
                chk(32'({rd[6:4], rd[2:0]}), 32'({2'b00, (a == 0), 3'(ST_RUN)}), "run state");
                if (a == 1) chk(32'({rd[19:16], rd[3]}), 32'({DLL_LOCK_CODE, 1'b1}), "lock");
                chk(32'(rd[14:8]), 32'(defs[g * 2 + a]), "variant delay");
                rxq.delete();
                slow_rises = 0;
                w1 = 8'hB6 & (8'hFF >> (8 - nb));
                w2 = 8'h59 & (8'hFF >> (8 - nb));
                tx.send(32'(w1), nb, 16);
                tx.send(32'(w2), nb, 16);
                repeat (40) @(posedge clk);
                chk(32'(rxq.size()), 32'h2, "word count");
                if (rxq.size() == 2) chk(32'({rxq[0], rxq[1]}), 32'({w1, w2}), "words");
                chk(32'(slow_rises), 32'h2, "slow clock");
                xfer(1'b0, OFS_WORD, 0);
                chk(rd, 32'(w2), "word register");
                $display("test variant %0d done", g * 2 + a);
            end
        end
        complete_run();
    end
endmodule : tb
